// file: verilog/jfp_pkg.sv
package jfp_pkg;
   // instruction codes
   localparam logic [3:0]  INSTR_TARGET_RESET  = 4'hC;
   localparam logic [3:0]  INSTR_UNLOCK        = 4'h4;
   localparam logic [3:0]  INSTR_COMMAND       = 4'h5;
   localparam logic [3:0]  INSTR_PAGE_FILL     = 4'h6;
   localparam logic [3:0]  INSTR_PAGE_FETCH    = 4'h7;
   localparam logic [3:0]  INSTR_BYPASS        = 4'hF;
   localparam logic [3:0]  IR_RESET_VAL        = 4'hF;
   localparam logic [3:0]  IR_CAPTURE_VAL      = 4'h1;
   // register widths and values
   localparam int          IR_W                = 4;
   localparam int          UNLOCK_W            = 16;
   localparam int          CMD_W               = 15;
   localparam int          BYTE_W              = 8;
   localparam logic [15:0] UNLOCK_SIGNATURE    = 16'hA370;
   localparam logic [15:0] UNLOCK_RESET_VAL    = 16'h0000;
   localparam logic [14:0] CMD_RESET_VAL       = 15'h0000;
   localparam logic [7:0]  BYTE_RESET_VAL      = 8'h00;
   // timing
   localparam int          REF_CLK_PERIOD_PS   = 5000;
   localparam int          PAGE_WRITE_TCK      = 11;
   localparam int          DISABLE_CLR_CLKS    = 2;
   localparam int          TIMEOUT_SHORT_CYC   = 64;
   localparam int          TIMEOUT_LONG_CYC    = 4096;
   localparam int          FIFO_DEPTH          = 32;

   typedef enum logic [3:0] {
      TS_RESET, TS_IDLE,
      TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAU_DR, TS_EX2_DR,
      TS_UPD_DR,
      TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAU_IR, TS_EX2_IR,
      TS_UPD_IR
   } jfp_tap_t;
endpackage : jfp_pkg

// file: verilog/jfp_prog_port.sv
`timescale 1ns/1ps
// Summary of operation
// R1: programming needs only the four test pins
// R2: port usable when fuse set, disable cleared
// R3: external reset low clears disable bit
// R4: programmer keeps test clock below chip maximum
// R5: all shift registers move LSB first
// R6: instruction register is four bits wide
// R7: code C selects target reset, TAP untouched
// R8: target reset unlatched, active while one
// R9: reset stretched by fuse-selected time-out
// R10: programmer resets part before programming
// R11: code 4 selects 16-bit unlock register
// R12: unlock match at update enters programming
// R13: unlock register cleared at power-on reset
// R14: code 5 command register captures result
// R15: shift out result, update applies command
// R16: one execute pulse per idle test clock
// R17: code 6 byte register, command low bits
// R18: page-fill byte buffered, written within 11; code waits on page_wr_ready with no limit
// R19: page-fill alternates low then high byte
// R20: address pre-increments before later low bytes
// R21: code 7 captures flash bytes low first
// R22: address post-increments after each high byte
// R23: failed unlock blocks programming instructions

////////////////////////////////////////////////////////////////////////////
module jfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   wire              push;
   wire              pop;

   assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr_r != rd_ptr_r;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
         rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
      end
   end
endmodule : jfp_fifo

////////////////////////////////////////////////////////////////////////////
module jfp_prog_port import jfp_pkg::*; #(
   parameter int ADDR_W      = 16,
   parameter int TO_SHORT    = TIMEOUT_SHORT_CYC,
   parameter int TO_LONG     = TIMEOUT_LONG_CYC,
   parameter int FILL_DEPTH  = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // test pins
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   output logic                   tdo,
   output logic                   tdo_oe,
   // enables and reset
   input  wire logic              test_port_enable_fuse,
   input  wire logic              ext_reset_b,
   input  wire logic              disable_wr,
   input  wire logic              disable_wr_val,
   output logic                   test_port_disable_bit,
   input  wire logic              timeout_long_fuse,
   output logic                   target_reset,
   output logic                   prog_mode,
   // flash command path
   output logic      [CMD_W-1:0]  flash_cmd,
   output logic                   flash_cmd_exec,
   input  wire logic [CMD_W-1:0]  flash_result,
   // address counter and page read
   input  wire logic              addr_load,
   input  wire logic [ADDR_W-1:0] addr_load_val,
   output logic      [ADDR_W-1:0] word_addr,
   input  wire logic [15:0]       flash_word,
   // page buffer write stream
   output logic                   page_wr_valid,
   input  wire logic              page_wr_ready,
   output logic      [ADDR_W-1:0] page_wr_addr,
   output logic                   page_wr_high,
   output logic      [7:0]        page_wr_data
);
   localparam int EW = ADDR_W + 1 + BYTE_W;

   // pin synchronisers: stage one feeds stage two only
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic       tck_prev_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r    <= 4'h8;
         sync2_r    <= 4'h8;
         tck_prev_r <= 1'b0;
      end else begin
         sync1_r    <= {ext_reset_b, tdi, tms, tck};
         sync2_r    <= sync1_r;
         tck_prev_r <= sync2_r[0];
      end
   end
   wire tck_s     = sync2_r[0];
   wire tms_s     = sync2_r[1];
   wire tdi_s     = sync2_r[2];
   wire ext_rst_s = sync2_r[3];
   wire tck_rise  = tck_s && !tck_prev_r;
   wire tck_fall  = !tck_s && tck_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // port enable and disable bit
   logic disable_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         disable_r <= 1'b0;
      end else if (!ext_rst_s) begin
         disable_r <= 1'b0;                                     // [R3]
      end else if (disable_wr) begin
         disable_r <= disable_wr_val;
      end
   end
   assign test_port_disable_bit = disable_r;
   wire port_en = test_port_enable_fuse && !disable_r;          // [R2] [R1]

   ////////////////////////////////////////////////////////////////////////
   // TAP controller, advanced on each sampled rising test clock
   jfp_tap_t tap_r;
   jfp_tap_t tap_nxt;
   always_comb begin
      case (tap_r)
         TS_RESET:  tap_nxt = tms_s ? TS_RESET  : TS_IDLE;
         TS_IDLE:   tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
         TS_SEL_DR: tap_nxt = tms_s ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: tap_nxt = tms_s ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR:  tap_nxt = tms_s ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: tap_nxt = tms_s ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: tap_nxt = tms_s ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: tap_nxt = tms_s ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
         TS_SEL_IR: tap_nxt = tms_s ? TS_RESET  : TS_CAP_IR;
         TS_CAP_IR: tap_nxt = tms_s ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR:  tap_nxt = tms_s ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: tap_nxt = tms_s ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: tap_nxt = tms_s ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: tap_nxt = tms_s ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
         default:   tap_nxt = TS_RESET;
      endcase
   end

   // a disabled port holds the controller in reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tap_r <= TS_RESET;
      end else if (!port_en) begin
         tap_r <= TS_RESET;                                     // [R2]
      end else if (tck_rise) begin
         tap_r <= tap_nxt;
      end
   end

   wire step    = port_en && tck_rise;
   wire cap_dr  = step && tap_r == TS_CAP_DR;
   wire sh_dr   = step && tap_r == TS_SH_DR;
   wire upd_dr  = step && tap_r == TS_UPD_DR;
   wire sh_ir   = step && tap_r == TS_SH_IR;
   wire upd_ir  = step && tap_r == TS_UPD_IR;
   wire shift_st = tap_r == TS_SH_DR || tap_r == TS_SH_IR;

   ////////////////////////////////////////////////////////////////////////
   // instruction register
   logic [IR_W-1:0] ir_sh_r;
   logic [IR_W-1:0] ir_r;
   logic            prog_mode_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_sh_r <= IR_RESET_VAL;
         ir_r    <= IR_RESET_VAL;
      end else if (tap_r == TS_RESET) begin
         ir_r    <= IR_RESET_VAL;
      end else if (step && tap_r == TS_CAP_IR) begin
         ir_sh_r <= IR_CAPTURE_VAL;
      end else if (sh_ir) begin
         ir_sh_r <= {tdi_s, ir_sh_r[IR_W-1:1]};                 // [R5] [R6]
      end else if (upd_ir) begin
         ir_r    <= ir_sh_r;
      end
   end

   wire sel_rst   = ir_r == INSTR_TARGET_RESET;                 // [R7]
   wire sel_unl   = ir_r == INSTR_UNLOCK;                       // [R11]
   wire sel_cmd   = ir_r == INSTR_COMMAND && prog_mode_r;       // [R14] [R23]
   wire sel_fill  = ir_r == INSTR_PAGE_FILL && prog_mode_r;     // [R17] [R23]
   wire sel_fetch = ir_r == INSTR_PAGE_FETCH && prog_mode_r;    // [R21] [R23]

   ////////////////////////////////////////////////////////////////////////
   // data registers
   logic              rst_bit_r;
   logic              bypass_r;
   logic [UNLOCK_W-1:0] unlock_r;
   logic [CMD_W-1:0]  cmd_sh_r;
   logic [CMD_W-1:0]  cmd_r;
   logic [ADDR_W-1:0] addr_r;
   logic              fill_high_r;
   logic              fill_first_r;
   logic              fetch_high_r;

   wire unlock_ok = unlock_r == UNLOCK_SIGNATURE;
   wire [7:0] fetch_byte = fetch_high_r ? flash_word[15:8]
                                        : flash_word[7:0];

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_bit_r   <= 1'b0;
         bypass_r    <= 1'b0;
         unlock_r    <= UNLOCK_RESET_VAL;                       // [R13]
         prog_mode_r <= 1'b0;
      end else begin
         if (sh_dr && sel_rst) begin
            rst_bit_r <= tdi_s;                                 // [R8]
         end
         if (sh_dr) begin
            bypass_r <= tdi_s;
         end
         if (sh_dr && sel_unl) begin
            unlock_r <= {tdi_s, unlock_r[UNLOCK_W-1:1]};        // [R11] [R5]
         end
         if (upd_dr && sel_unl) begin
            prog_mode_r <= unlock_ok;                           // [R12] [R23]
         end
      end
   end

   // command register; the byte register is its low eight bits
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_sh_r <= CMD_RESET_VAL;
         cmd_r    <= CMD_RESET_VAL;
      end else if (cap_dr && sel_cmd) begin
         cmd_sh_r <= flash_result;                              // [R14]
      end else if (cap_dr && sel_fetch) begin
         cmd_sh_r[BYTE_W-1:0] <= fetch_byte;                    // [R21] [R17]
      end else if (sh_dr && sel_cmd) begin
         cmd_sh_r <= {tdi_s, cmd_sh_r[CMD_W-1:1]};              // [R15] [R5]
      end else if (sh_dr && (sel_fill || sel_fetch)) begin
         cmd_sh_r[BYTE_W-1:0] <= {tdi_s, cmd_sh_r[BYTE_W-1:1]}; // [R17] [R5]
      end else if (upd_dr && sel_cmd) begin
         cmd_r <= cmd_sh_r;                                     // [R15]
      end
   end
   assign flash_cmd = cmd_r;

   // one execute pulse per rising test clock spent in idle while the command instruction is selected in programming mode
   logic exec_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         exec_r <= 1'b0;
      end else begin
         exec_r <= step && tap_r == TS_IDLE && sel_cmd;         // [R16]
      end
   end
   assign flash_cmd_exec = exec_r;

   ////////////////////////////////////////////////////////////////////////
   // word address counter, byte alternation and page buffer entry
   wire enter_instr = upd_ir;
   wire fill_upd    = upd_dr && sel_fill;
   wire fetch_cap   = cap_dr && sel_fetch;
   wire fill_inc    = fill_upd && !fill_high_r && !fill_first_r; // [R20]
   wire fetch_inc   = fetch_cap && fetch_high_r;                // [R22]
   wire [ADDR_W-1:0] fill_addr = fill_inc ? addr_r + ADDR_W'(1) : addr_r;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_r       <= '0;
         fill_high_r  <= 1'b0;
         fill_first_r <= 1'b1;
         fetch_high_r <= 1'b0;
      end else begin
         if (addr_load) begin
            addr_r <= addr_load_val;
         end else if (fill_inc || fetch_inc) begin
            addr_r <= addr_r + ADDR_W'(1);                      // [R20] [R22]
         end
         if (enter_instr) begin
            fill_high_r  <= 1'b0;                               // [R19]
            fill_first_r <= 1'b1;
            fetch_high_r <= 1'b0;                               // [R21]
         end else begin
            if (fill_upd) begin
               fill_high_r  <= !fill_high_r;                    // [R19]
               fill_first_r <= 1'b0;
            end
            if (fetch_cap) begin
               fetch_high_r <= !fetch_high_r;                   // [R21]
            end
         end
      end
   end
   assign word_addr = addr_r;

   // temporary register; waits here while the buffer is full
   logic [EW-1:0] temp_r;
   logic          temp_vld_r;
   logic          fifo_ready;
   logic [EW-1:0] fifo_out;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_r     <= '0;
         temp_vld_r <= 1'b0;
      end else if (fill_upd) begin
         temp_r     <= {fill_addr, fill_high_r,
                        cmd_sh_r[BYTE_W-1:0]};                  // [R18]
         temp_vld_r <= 1'b1;
      end else if (fifo_ready) begin
         temp_vld_r <= 1'b0;
      end
   end

   // the page buffer drains at its own pace; entries land well inside
   // the write window while the sink keeps up with the test clock
   jfp_fifo #(
      .WIDTH (EW),
      .DEPTH (FILL_DEPTH)
   ) u_fill_fifo (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .in_valid  (temp_vld_r),
      .in_ready  (fifo_ready),
      .in_data   (temp_r),                                      // [R18]
      .out_valid (page_wr_valid),
      .out_ready (page_wr_ready),
      .out_data  (fifo_out)
   );
   assign page_wr_data = fifo_out[BYTE_W-1:0];
   assign page_wr_high = fifo_out[BYTE_W];
   assign page_wr_addr = fifo_out[EW-1:BYTE_W+1];

   ////////////////////////////////////////////////////////////////////////
   // target reset, live from the bit and stretched by the time-out
   logic [12:0] tout_r;
   wire  [12:0] tout_len = timeout_long_fuse ? 13'(TO_LONG)
                                             : 13'(TO_SHORT);
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tout_r <= '0;
      end else if (rst_bit_r && sel_rst) begin
         tout_r <= tout_len;                                    // [R9]
      end else if (tout_r != 13'h0000) begin
         tout_r <= tout_r - 13'h0001;
      end
   end
   // combinational on purpose: reset takes effect at once
   assign target_reset = (rst_bit_r && sel_rst) || tout_r != 13'h0000; // [R8]
   assign prog_mode    = prog_mode_r;

   ////////////////////////////////////////////////////////////////////////
   // test data out changes on the falling test clock
   wire tdo_bit = tap_r == TS_SH_IR ? ir_sh_r[0]
                : sel_rst           ? rst_bit_r
                : sel_unl           ? unlock_r[0]
                : (sel_cmd || sel_fill || sel_fetch) ? cmd_sh_r[0]
                : bypass_r;
   logic tdo_r;
   logic tdo_oe_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else if (!port_en) begin
         tdo_oe_r <= 1'b0;
      end else if (tck_fall) begin
         tdo_r    <= tdo_bit;                                   // [R5] [R15]
         tdo_oe_r <= shift_st;
      end
   end
   assign tdo    = tdo_r;
   assign tdo_oe = tdo_oe_r;
endmodule : jfp_prog_port

// file: dv/jfp_prog_port_sva.sv
`timescale 1ns/1ps
module jfp_prog_port_sva import jfp_pkg::*; #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rst_b,
   // enables and reset
   input wire logic              test_port_enable_fuse,
   input wire logic              ext_reset_b,
   input wire logic              disable_wr,
   input wire logic              disable_wr_val,
   input wire logic              test_port_disable_bit,
   input wire logic              tdo_oe,
   input wire logic              target_reset,
   input wire logic              prog_mode,
   // command and address
   input wire logic [CMD_W-1:0]  flash_cmd,
   input wire logic              flash_cmd_exec,
   input wire logic              addr_load,
   input wire logic [ADDR_W-1:0] addr_load_val,
   input wire logic [ADDR_W-1:0] word_addr,
   // page write stream
   input wire logic              page_wr_valid,
   input wire logic              page_wr_ready,
   input wire logic [ADDR_W-1:0] page_wr_addr,
   input wire logic              page_wr_high,
   input wire logic [7:0]        page_wr_data
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   chk_exec_pulse: assert property (
      flash_cmd_exec |=> !flash_cmd_exec) else $error("exec too long");
   chk_exec_locked: assert property (
      flash_cmd_exec |-> prog_mode) else $error("exec while locked");
   chk_exec_cmd: assert property (
      flash_cmd_exec |-> $stable(flash_cmd)) else $error("cmd moved at exec");
   chk_oe_gated: assert property (
      (!test_port_enable_fuse || test_port_disable_bit) [*2] |-> !tdo_oe)
      else $error("tdo driven while port off");
   chk_dis_clear: assert property (
      !ext_reset_b && test_port_disable_bit |-> ##[1:4] !test_port_disable_bit)
      else $error("disable bit not cleared");
   chk_dis_write: assert property (
      ext_reset_b [*5] ##0 disable_wr
      |=> test_port_disable_bit == $past(disable_wr_val))
      else $error("disable write lost");
   chk_tr_stretch: assert property (
      $rose(target_reset) |-> target_reset [*8]) else $error("reset short");
   chk_fill_hold: assert property (
      page_wr_valid && !page_wr_ready |=> page_wr_valid && $stable(page_wr_addr)
      && $stable(page_wr_high) && $stable(page_wr_data))
      else $error("page write dropped");
   chk_addr_step: assert property (
      $changed(word_addr) && !$past(addr_load)
      |-> word_addr - $past(word_addr) == ADDR_W'(1))
      else $error("address jump");
   chk_addr_load: assert property (
      addr_load |=> word_addr == $past(addr_load_val))
      else $error("address load lost");

   cov_exec: cover property (flash_cmd_exec);
   cov_fill: cover property (page_wr_valid && page_wr_ready);
   cov_unlock: cover property ($rose(prog_mode));
endmodule : jfp_prog_port_sva

bind jfp_prog_port jfp_prog_port_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// file: dv/jfp_jtag_host.sv
`timescale 1ns/1ps
// external programmer: tck idles low between frames
module jfp_jtag_host (
   // test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic q;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // 48 ns period keeps tck far below the chip clock
   task step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #24;
      o = tdo;
      tck = 1'b1;
      #24;
      tck = 1'b0;
   endtask : step

   task tlr;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : tlr

   task idle(input int n);
      repeat (n) step(1'b0, 1'b0, q);
   endtask : idle

   task scan(input logic ir, input int n, input logic [15:0] din,
             output logic [15:0] dout);
      dout = '0;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask : scan
endmodule : jfp_jtag_host

// file: dv/tb.sv
`timescale 1ns/1ps
module tb import jfp_pkg::*;;
   typedef struct {logic [14:0] cmd; logic [14:0] res; int n;} jfp_row_t;
   logic        ref_clk = 1'b0, rst_b, tck, tms, tdi, tdo, tdo_oe;
   logic        test_port_enable_fuse, ext_reset_b, disable_wr;
   logic        disable_wr_val, test_port_disable_bit, timeout_long_fuse;
   logic        target_reset, prog_mode, flash_cmd_exec, addr_load;
   logic        page_wr_valid, page_wr_ready, page_wr_high;
   logic [14:0] flash_cmd, flash_result;
   logic [15:0] addr_load_val, word_addr, flash_word, page_wr_addr, q;
   logic [7:0]  page_wr_data;
   int          num_errors = 0, n_tests = 0, n_exec = 0, n_oe = 0, e0;
   jfp_row_t    rows [3] = '{'{15'h2310, 15'h7FFF, 1},
                             '{15'h4C00, 15'h0001, 3},
                             '{15'h0000, 15'h5555, 2}};

   jfp_prog_port #(.TO_SHORT(8), .TO_LONG(64)) u_dut (.*);
   jfp_jtag_host u_host (.*);

   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (flash_cmd_exec) n_exec <= n_exec + 1;
      if (tdo_oe) n_oe <= n_oe + 1;
   end
   always @(negedge ref_clk) flash_word <= {~word_addr[7:0], word_addr[7:0]};

   ////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : check

   task stop_test;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task load_addr(input logic [15:0] a);
      @(negedge ref_clk);
      addr_load = 1'b1;
      addr_load_val = a;
      @(negedge ref_clk);
      addr_load = 1'b0;
   endtask : load_addr

   task wait_valid;
      int k;
      for (k = 0; k < 200 && page_wr_valid !== 1'b1; k++) @(negedge ref_clk);
      if (k == 200) begin
         num_errors++;
         stop_test;
      end
   endtask : wait_valid

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400us;
      num_errors++;
      stop_test;
   end

   initial begin
      {rst_b, disable_wr, disable_wr_val, timeout_long_fuse, addr_load} = '0;
      {test_port_enable_fuse, ext_reset_b, page_wr_ready} = 3'h7;
      addr_load_val = 16'h0000;
      flash_result = 15'h0000;
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      check({prog_mode, target_reset, test_port_disable_bit, tdo_oe}, 0);
      u_host.tlr();
      // part reset through the test port before unlocking
      u_host.scan(1'b1, 4, INSTR_TARGET_RESET, q);
      check(q[3:0], IR_CAPTURE_VAL);
      u_host.scan(1'b0, 1, 16'h0001, q);
      check(target_reset, 1'b1);
      u_host.scan(1'b1, 4, INSTR_TARGET_RESET, q);
      check(q[3:0], IR_CAPTURE_VAL);
      @(negedge ref_clk);
      timeout_long_fuse = 1'b1;
      u_host.scan(1'b0, 1, 16'h0000, q);
      // the long stretch still runs; the short one would be over by now
      check(target_reset, 1'b1);
      #300;
      check(target_reset, 1'b0);
      // one bit off the signature must stay locked
      u_host.scan(1'b1, 4, INSTR_UNLOCK, q);
      u_host.scan(1'b0, 16, 16'hA371, q);
      check(prog_mode, 1'b0);
      u_host.scan(1'b1, 4, INSTR_COMMAND, q);
      u_host.scan(1'b0, 15, 16'h1234, q);
      e0 = n_exec;
      u_host.idle(2);
      #30;
      check(n_exec - e0, 0);
      u_host.scan(1'b1, 4, INSTR_UNLOCK, q);
      u_host.scan(1'b0, 16, 16'hA370, q);
      check(prog_mode, 1'b1);
      u_host.scan(1'b1, 4, INSTR_COMMAND, q);
      foreach (rows[i]) begin
         @(negedge ref_clk);
         flash_result = rows[i].res;
         u_host.scan(1'b0, 15, {1'b0, rows[i].cmd}, q);
         check(q[14:0], rows[i].res);
         check(flash_cmd, rows[i].cmd);
         e0 = n_exec;
         u_host.idle(rows[i].n);
         #30;
         check(n_exec - e0, rows[i].n);
      end
      // page fill with the drain stalled past the buffer depth
      load_addr(16'h0040);
      @(negedge ref_clk);
      page_wr_ready = 1'b0;
      u_host.scan(1'b1, 4, INSTR_PAGE_FILL, q);
      for (int i = 0; i < 33; i++) u_host.scan(1'b0, 8, 16'(8'h10 + i), q);
      check(word_addr, 16'h0050);
      for (int i = 0; i < 33; i++) begin
         wait_valid;
         check({page_wr_addr, page_wr_high, page_wr_data},
               {16'(16'h0040 + i / 2), i[0], 8'(8'h10 + i)});
         page_wr_ready = 1'b1;
         @(negedge ref_clk);
         page_wr_ready = 1'b0;
      end
      repeat (3) @(negedge ref_clk);
      check(page_wr_valid, 1'b0);
      // page fetch: low then high, address steps after high
      load_addr(16'h0080);
      u_host.scan(1'b1, 4, INSTR_PAGE_FETCH, q);
      for (int i = 0; i < 4; i++) begin
         u_host.scan(1'b0, 8, 16'h0000, q);
         check(q[7:0], 8'(i[0] ? ~(8'h80 + 8'(i / 2)) : 8'h80 + 8'(i / 2)));
      end
      check(word_addr, 16'h0082);
      // disable bit set blocks the port, external reset frees it
      @(negedge ref_clk);
      {disable_wr, disable_wr_val} = 2'h3;
      @(negedge ref_clk);
      disable_wr = 1'b0;
      check(test_port_disable_bit, 1'b1);
      e0 = n_oe;
      u_host.scan(1'b1, 4, INSTR_BYPASS, q);
      check(n_oe - e0, 0);
      @(negedge ref_clk);
      ext_reset_b = 1'b0;
      repeat (6) @(negedge ref_clk);
      check(test_port_disable_bit, 1'b0);
      ext_reset_b = 1'b1;
      u_host.tlr();
      e0 = n_oe;
      u_host.scan(1'b1, 4, INSTR_BYPASS, q);
      check(q[3:0], IR_CAPTURE_VAL);
      check(n_oe != e0, 1'b1);
      @(negedge ref_clk);
      test_port_enable_fuse = 1'b0;
      e0 = n_oe;
      u_host.scan(1'b1, 4, INSTR_BYPASS, q);
      check(n_oe - e0, 0);
      test_port_enable_fuse = 1'b1;
      @(negedge ref_clk);
      rst_b = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      check(prog_mode, 1'b0);
      stop_test;
   end
endmodule : tb
